/* src/hpec_defs.svh */
// Purpose: Offsets, field positions and reset values of the hibernation event controller
// Assumes: AHB-Lite, 32-bit words, byte addresses
// Notes:   Constants only
`ifndef HPEC_DEFS_SVH
`define HPEC_DEFS_SVH
// Register byte offsets
`define HPEC_OFS_CTRL      8'h00
`define HPEC_OFS_ENABLE    8'h04
`define HPEC_OFS_DISABLE   8'h08
`define HPEC_OFS_RAW       8'h0C
`define HPEC_OFS_MASKED    8'h10
`define HPEC_OFS_CLEAR     8'h14
`define HPEC_OFS_BATTERY   8'h18
`define HPEC_OFS_WAKECFG   8'h1C
`define HPEC_OFS_MATCH     8'h20
`define HPEC_OFS_SECONDS   8'h24
`define HPEC_OFS_REQUEST   8'h28
`define HPEC_OFS_STATUSSEL 8'h2C
// Event bit positions, common to enable, raw, masked and clear
`define HPEC_EV_WRITE_DONE 0
`define HPEC_EV_PIN_WAKE   1
`define HPEC_EV_LOW_BAT    2
`define HPEC_EV_RTC_MATCH  3
`define HPEC_EV_SUPPLY     4
`define HPEC_EV_RESET_WAKE 5
`define HPEC_EV_GPIO_WAKE  6
`define HPEC_NUM_EV        7
// Control register fields
`define HPEC_CTRL_ACTIVE   0
`define HPEC_CTRL_RETAIN   1
// Battery register fields
`define HPEC_BAT_DETECT    0
`define HPEC_BAT_ABORT     1
`define HPEC_BAT_THR_LO    4
`define HPEC_BAT_THR_HI    5
// Wake configuration fields
`define HPEC_WK_PIN        0
`define HPEC_WK_RTC        1
`define HPEC_WK_GPIO       2
`define HPEC_WK_RESET      3
`define HPEC_WK_LOW_BAT    4
// Request and status select register fields
`define HPEC_REQ_GO        0
`define HPEC_SEL_MASKED    0
// Reset values
`define HPEC_RST_WORD      32'h0000_0000
`define HPEC_RST_EV        7'h00
`define HPEC_RST_THR       2'h0
`endif

/* src/hpec_pkg.sv */
// Purpose: Types of the hibernation event controller
// Assumes: Included constants header
// Notes:   Power state and threshold enumerations
package hpec_pkg;
  `include "hpec_defs.svh"
  typedef enum logic [2:0] {
    HPEC_ST_RUN  = 3'b001,
    HPEC_ST_HIB  = 3'b010,
    HPEC_ST_WAKE = 3'b100
  } hpec_state_e;
  typedef enum logic [1:0] {
    HPEC_THR_LOWEST  = 2'h0,
    HPEC_THR_SECOND  = 2'h1,
    HPEC_THR_THIRD   = 2'h2,
    HPEC_THR_HIGHEST = 2'h3
  } hpec_thr_e;
  typedef logic [`HPEC_NUM_EV-1:0] hpec_ev_t;
endpackage

/* src/hpec_top.sv */
// Purpose: Hibernation event flags, low-battery control and regulator enable
// Assumes: CLOCK 50 MHz; RSTN is the controller's own reset, not the system POR
// Notes:   AHB-Lite slave, zero wait states, always OKAY
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "hpec_defs.svh"
module hpec_top
  import hpec_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Event sources from pins and analog
  input  wire logic        WAKE_PIN,
  input  wire logic        RESET_PIN_WAKE,
  input  wire logic        GPIO_WAKE,
  input  wire logic        SUPPLY_FAIL,
  input  wire logic [3:0]  BATTERY_BELOW,
  // Seconds count from the counter
  input  wire logic [31:0] SECONDS,
  // Outputs
  output logic             IRQ,
  output logic             REGULATOR_EN,
  output logic       [1:0] BATTERY_THRESHOLD,
  output logic             GPIO_RETAIN
);
  import hpec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: two flops before any logic
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync_in;
  assign sync_in = {BATTERY_BELOW, SUPPLY_FAIL, GPIO_WAKE, RESET_PIN_WAKE, WAKE_PIN};
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
    end
  end
  logic       pin_s;
  logic       rst_s;
  logic       gpio_s;
  logic       sup_s;
  logic [3:0] below_s;
  assign pin_s   = sync2_reg[0];
  assign rst_s   = sync2_reg[1];
  assign gpio_s  = sync2_reg[2];
  assign sup_s   = sync2_reg[3];
  assign below_s = sync2_reg[7:4];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture
  logic       wr_pend_reg;
  logic       wr_pend_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic       take;
  assign take = HSEL && HREADY && HTRANS[1];
  // Registers address for the write data phase
  always_comb begin
    wr_pend_next = take && HWRITE;
    addr_next    = take ? HADDR : addr_reg;
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= wr_pend_next;
      addr_reg    <= addr_next;
    end
  end
  logic wr_en, wr_clr, wr_dis, wr_bat, wr_wk, wr_ctl, wr_mat, wr_req, wr_sel;
  assign wr_en  = wr_pend_reg && addr_reg == `HPEC_OFS_ENABLE;
  assign wr_dis = wr_pend_reg && addr_reg == `HPEC_OFS_DISABLE;
  assign wr_clr = wr_pend_reg && addr_reg == `HPEC_OFS_CLEAR;
  assign wr_bat = wr_pend_reg && addr_reg == `HPEC_OFS_BATTERY;
  assign wr_wk  = wr_pend_reg && addr_reg == `HPEC_OFS_WAKECFG;
  assign wr_ctl = wr_pend_reg && addr_reg == `HPEC_OFS_CTRL;
  assign wr_mat = wr_pend_reg && addr_reg == `HPEC_OFS_MATCH;
  assign wr_req = wr_pend_reg && addr_reg == `HPEC_OFS_REQUEST;
  assign wr_sel = wr_pend_reg && addr_reg == `HPEC_OFS_STATUSSEL;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; only RSTN clears them, never the system POR
  hpec_ev_t   enable_reg;
  hpec_ev_t   enable_next;
  logic       active_reg;
  logic       active_next;
  logic       retain_reg;
  logic       retain_next;
  logic       detect_reg;
  logic       detect_next;
  logic       abort_reg;
  logic       abort_next;
  logic [1:0] thr_reg;
  logic [1:0] thr_next;
  logic [4:0] wake_cfg_reg;
  logic [4:0] wake_cfg_next;
  logic [31:0] match_reg;
  logic [31:0] match_next;
  logic       masked_status_select_reg;
  logic       masked_status_select_next;
  always_comb begin
    enable_next = enable_reg;
    if (wr_en) enable_next = enable_reg | HWDATA[`HPEC_NUM_EV-1:0];
    if (wr_dis) enable_next = enable_reg & ~HWDATA[`HPEC_NUM_EV-1:0];
    active_next = wr_ctl ? HWDATA[`HPEC_CTRL_ACTIVE] : active_reg;
    retain_next = wr_ctl ? HWDATA[`HPEC_CTRL_RETAIN] : retain_reg;
    detect_next = wr_bat ? HWDATA[`HPEC_BAT_DETECT] : detect_reg;
    abort_next  = wr_bat ? HWDATA[`HPEC_BAT_ABORT] : abort_reg;
    thr_next    = wr_bat ? HWDATA[`HPEC_BAT_THR_HI:`HPEC_BAT_THR_LO] : thr_reg;
    wake_cfg_next = wr_wk ? HWDATA[`HPEC_WK_LOW_BAT:`HPEC_WK_PIN] : wake_cfg_reg;
    match_next  = wr_mat ? HWDATA : match_reg;
    masked_status_select_next = wr_sel ? HWDATA[`HPEC_SEL_MASKED] : masked_status_select_reg;
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      enable_reg   <= `HPEC_RST_EV;
      active_reg   <= 1'b0;
      retain_reg   <= 1'b0;
      detect_reg   <= 1'b0;
      abort_reg    <= 1'b0;
      thr_reg      <= `HPEC_RST_THR;
      wake_cfg_reg <= 5'h00;
      match_reg    <= `HPEC_RST_WORD;
      masked_status_select_reg <= 1'b0;
    end else begin
      enable_reg   <= enable_next;
      active_reg   <= active_next;
      retain_reg   <= retain_next;
      detect_reg   <= detect_next;
      abort_reg    <= abort_next;
      thr_reg      <= thr_next;
      wake_cfg_reg <= wake_cfg_next;
      match_reg    <= match_next;
      masked_status_select_reg <= masked_status_select_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection and sticky flags
  logic     low_battery;
  logic     rtc_hit;
  logic     pin_d_reg;
  logic     rst_d_reg;
  logic     gpio_d_reg;
  logic     sup_d_reg;
  logic     rtc_d_reg;
  hpec_ev_t ev_set;
  hpec_ev_t raw_reg;
  hpec_ev_t raw_next;
  assign low_battery = detect_reg && below_s[thr_reg];
  assign rtc_hit     = SECONDS == match_reg;
  // Rising edges except write done, set by every write, and low battery, a level that refills a cleared flag while it holds
  always_comb begin
    ev_set = '0;
    ev_set[`HPEC_EV_WRITE_DONE] = wr_pend_reg;
    ev_set[`HPEC_EV_PIN_WAKE]   = pin_s && !pin_d_reg;
    ev_set[`HPEC_EV_LOW_BAT]    = low_battery;
    ev_set[`HPEC_EV_RTC_MATCH]  = rtc_hit && !rtc_d_reg;
    ev_set[`HPEC_EV_SUPPLY]     = sup_s && !sup_d_reg;
    ev_set[`HPEC_EV_RESET_WAKE] = rst_s && !rst_d_reg;
    ev_set[`HPEC_EV_GPIO_WAKE]  = (gpio_s && !gpio_d_reg) || (rst_s && !rst_d_reg);
    // Set wins over a clear in the same cycle
    raw_next = (raw_reg & ~(wr_clr ? HWDATA[`HPEC_NUM_EV-1:0] : '0)) | ev_set;
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      raw_reg    <= `HPEC_RST_EV;
      pin_d_reg  <= 1'b0;
      rst_d_reg  <= 1'b0;
      gpio_d_reg <= 1'b0;
      sup_d_reg  <= 1'b0;
      rtc_d_reg  <= 1'b1;  // Seconds and match both reset to zero: no false match
    end else begin
      raw_reg    <= raw_next;
      pin_d_reg  <= pin_s;
      rst_d_reg  <= rst_s;
      gpio_d_reg <= gpio_s;
      sup_d_reg  <= sup_s;
      rtc_d_reg  <= rtc_hit;
    end
  end
  hpec_ev_t masked;
  assign masked = raw_reg & enable_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine driving the regulator enable
  hpec_state_e state_reg;
  hpec_state_e state_next;
  logic        wake_hit;
  logic        req_go;
  assign req_go   = wr_req && HWDATA[`HPEC_REQ_GO] && active_reg;
  assign wake_hit = (wake_cfg_reg[`HPEC_WK_PIN]   && pin_s) ||
                    (wake_cfg_reg[`HPEC_WK_RTC]   && rtc_hit) ||
                    (wake_cfg_reg[`HPEC_WK_GPIO]  && gpio_s) ||
                    (wake_cfg_reg[`HPEC_WK_RESET] && rst_s) ||
                    (wake_cfg_reg[`HPEC_WK_LOW_BAT] && low_battery);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HPEC_ST_RUN: begin
        // Abort keeps power on while the battery is low
        if (req_go && !(abort_reg && low_battery)) state_next = HPEC_ST_HIB;
      end
      HPEC_ST_HIB: begin
        if (wake_hit) state_next = HPEC_ST_WAKE;
      end
      HPEC_ST_WAKE: begin
        state_next = HPEC_ST_RUN;
      end
      default: state_next = HPEC_ST_RUN;
    endcase
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) state_reg <= HPEC_ST_RUN;
    else state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs and read data
  logic [31:0] rdata_next;
  logic        irq_reg;
  logic        reg_en_reg;
  always_comb begin
    rdata_next = HRDATA;
    if (take && !HWRITE) begin
      rdata_next = `HPEC_RST_WORD;
      unique case (HADDR)
        `HPEC_OFS_CTRL: begin
          rdata_next[`HPEC_CTRL_ACTIVE] = active_reg;
          rdata_next[`HPEC_CTRL_RETAIN] = retain_reg;
        end
        `HPEC_OFS_ENABLE:  rdata_next[`HPEC_NUM_EV-1:0] = enable_reg;
        `HPEC_OFS_RAW:     rdata_next[`HPEC_NUM_EV-1:0] = raw_reg;
        `HPEC_OFS_MASKED:  rdata_next[`HPEC_NUM_EV-1:0] =
                             masked_status_select_reg ? masked : raw_reg;
        `HPEC_OFS_BATTERY: begin
          rdata_next[`HPEC_BAT_DETECT] = detect_reg;
          rdata_next[`HPEC_BAT_ABORT]  = abort_reg;
          rdata_next[`HPEC_BAT_THR_HI:`HPEC_BAT_THR_LO] = thr_reg;
        end
        `HPEC_OFS_WAKECFG:   rdata_next[`HPEC_WK_LOW_BAT:`HPEC_WK_PIN] = wake_cfg_reg;
        `HPEC_OFS_MATCH:     rdata_next = match_reg;
        `HPEC_OFS_SECONDS:   rdata_next = SECONDS;
        `HPEC_OFS_STATUSSEL: rdata_next[`HPEC_SEL_MASKED] = masked_status_select_reg;
        default:             rdata_next = `HPEC_RST_WORD;
      endcase
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      HRDATA     <= `HPEC_RST_WORD;
      irq_reg    <= 1'b0;
      reg_en_reg <= 1'b1;
    end else begin
      HRDATA     <= rdata_next;
      irq_reg    <= |masked;
      reg_en_reg <= state_next != HPEC_ST_HIB;
    end
  end
  assign HREADYOUT         = 1'b1;
  assign HRESP             = 1'b0;
  assign IRQ               = irq_reg;
  assign REGULATOR_EN      = reg_en_reg;
  assign BATTERY_THRESHOLD = thr_reg;
  assign GPIO_RETAIN       = retain_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_irq_follows: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (|(raw_reg & enable_reg)) |=> IRQ) else $error("IRQ missing for pending event");
  a_disable_mask: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (wr_dis && !wr_en) |=>
      (enable_reg == ($past(enable_reg) & ~$past(HWDATA[`HPEC_NUM_EV-1:0]))))
    else $error("Disable left an enable set");
  a_enable_mask: assert property (@(posedge CLOCK) disable iff (!RSTN)
    wr_en |=> ((enable_reg & $past(HWDATA[`HPEC_NUM_EV-1:0])) == $past(HWDATA[`HPEC_NUM_EV-1:0])))
    else $error("Enable not set");
  a_flag_sticky: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (raw_reg[`HPEC_EV_PIN_WAKE] && !wr_clr) |=> raw_reg[`HPEC_EV_PIN_WAKE])
    else $error("Flag dropped without clear");
  a_reset_gpio: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (rst_s && !rst_d_reg) |=> (raw_reg[`HPEC_EV_RESET_WAKE] && raw_reg[`HPEC_EV_GPIO_WAKE]))
    else $error("Reset wake did not set both flags");
  a_abort_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_reg == HPEC_ST_RUN && abort_reg && low_battery) |=> REGULATOR_EN)
    else $error("Regulator dropped under abort");
  a_hib_drop: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_reg == HPEC_ST_RUN && req_go && !(abort_reg && low_battery)) |=> !REGULATOR_EN)
    else $error("Regulator not dropped on request");
  a_wake_up: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_reg == HPEC_ST_HIB && wake_hit) |=> ##1 REGULATOR_EN)
    else $error("Regulator not restored on wake");
  a_rtc_flag: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (rtc_hit && !rtc_d_reg) |=> raw_reg[`HPEC_EV_RTC_MATCH]) else $error("RTC flag not set");
  c_hib_cycle: cover property (@(posedge CLOCK) disable iff (!RSTN)
    state_reg == HPEC_ST_HIB ##[1:50] state_reg == HPEC_ST_WAKE);
  c_refused: cover property (@(posedge CLOCK) disable iff (!RSTN) req_go && abort_reg && low_battery);
  c_irq: cover property (@(posedge CLOCK) disable iff (!RSTN) $rose(IRQ));
endmodule
`default_nettype wire

/* tb/hpec_regulator_model.sv */
// Purpose: Behavioural external regulator fed by the power enable
// Assumes: Enable high asks for the supply to be on
// Notes:   Rail follows the enable after a short settle delay
`timescale 1ns/1ns
`default_nettype none
module hpec_regulator_model (
  // Clock and control
  input  wire logic clk,
  input  wire logic enable,
  // Supply state
  output logic      power_good
);
  logic [2:0] settle_reg;
  // The rail ramps slowly, so software sees power removal late
  always_ff @(posedge clk) begin
    settle_reg <= {settle_reg[1:0], enable};
  end
  assign power_good = settle_reg[2];
endmodule
`default_nettype wire

/* tb/hpec_top_test.sv */
// Purpose: Self-checking bench of the hibernation event controller
// Assumes: Zero-wait AHB-Lite slave, event pins synchronised inside
// Notes:   Regulator model closes the power loop
`timescale 1ns/1ns
`default_nettype none
`include "hpec_defs.svh"
module hpec_top_test;
  import hpec_pkg::*;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic HSEL = 1'b1;
  logic [7:0] HADDR = 8'h00;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic [3:0] pins = 4'h0;
  logic [3:0] BATTERY_BELOW = 4'h0;
  logic [31:0] SECONDS = 32'h0;
  logic IRQ;
  logic REGULATOR_EN;
  logic [1:0] BATTERY_THRESHOLD;
  logic GPIO_RETAIN;
  logic power_good;
  int failures = 0;
  int total_checks = 0;
  //////////////////////////////////////////////////////////////////////////
  // Clock, design and far-side regulator
  always #10 CLOCK = ~CLOCK;
  hpec_top i_hpec_top (
    .CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .WAKE_PIN(pins[0]), .RESET_PIN_WAKE(pins[1]), .GPIO_WAKE(pins[2]),
    .SUPPLY_FAIL(pins[3]), .BATTERY_BELOW(BATTERY_BELOW), .SECONDS(SECONDS),
    .IRQ(IRQ), .REGULATOR_EN(REGULATOR_EN), .BATTERY_THRESHOLD(BATTERY_THRESHOLD),
    .GPIO_RETAIN(GPIO_RETAIN));
  hpec_regulator_model i_hpec_regulator_model (
    .clk(CLOCK), .enable(REGULATOR_EN), .power_good(power_good));
  //////////////////////////////////////////////////////////////////////////
  // Shared checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One whole-word transfer; waits for ready at both phases, never assumes it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLOCK);
    HADDR <= a;
    HWRITE <= w;
    HTRANS <= 2'h2;
    do begin
      @(posedge CLOCK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 50);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 100);
    q = HRDATA;
    if (n >= 100) chk(32'h0, 32'h1);
    chk({31'h0, HRESP}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // Hold the pins long enough for the two-flop synchronisers
  task automatic pulse(input logic [3:0] m);
    pins <= m;
    repeat (4) @(posedge CLOCK);
    pins <= 4'h0;
    repeat (6) @(posedge CLOCK);
  endtask
  // Bounded wait on the supply; software must tolerate a late change
  task automatic wait_power(input logic v);
    int n;
    for (n = 0; n < 40 && power_good !== v; n++) @(posedge CLOCK);
    chk({31'h0, power_good}, {31'h0, v});
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(`HPEC_OFS_RAW, 32'h0);
    rd(`HPEC_OFS_CTRL, 32'h0);
    rd(`HPEC_OFS_ENABLE, 32'h0);
    rd(8'h3C, 32'h0);
    chk({31'h0, REGULATOR_EN}, 32'h1);
  endtask
  task automatic t_masks();
    wr(`HPEC_OFS_ENABLE, 32'h7F);
    wr(`HPEC_OFS_DISABLE, 32'h1D);
    rd(`HPEC_OFS_ENABLE, 32'h62);
  endtask
  // Writes set the write-done flag, so bit 0 appears in every raw value
  task automatic t_events();
    wr(`HPEC_OFS_CLEAR, 32'h7F);
    pulse(4'h2);
    rd(`HPEC_OFS_RAW, 32'h61);
    wr(`HPEC_OFS_STATUSSEL, 32'h1);
    rd(`HPEC_OFS_MASKED, 32'h60);
    chk({31'h0, IRQ}, 32'h1);
    wr(`HPEC_OFS_CLEAR, 32'h20);
    rd(`HPEC_OFS_RAW, 32'h41);
    chk({31'h0, IRQ}, 32'h1);
    wr(`HPEC_OFS_CLEAR, 32'h40);
    repeat (3) @(posedge CLOCK);
    chk({31'h0, IRQ}, 32'h0);
    pulse(4'h9);
    rd(`HPEC_OFS_MASKED, 32'h02);
    wr(`HPEC_OFS_STATUSSEL, 32'h0);
    rd(`HPEC_OFS_MASKED, 32'h13);
  endtask
  task automatic t_match();
    wr(`HPEC_OFS_MATCH, 32'h5);
    wr(`HPEC_OFS_CLEAR, 32'h7F);
    SECONDS <= 32'h4;
    repeat (3) @(posedge CLOCK);
    rd(`HPEC_OFS_RAW, 32'h01);
    SECONDS <= 32'h5;
    repeat (3) @(posedge CLOCK);
    rd(`HPEC_OFS_RAW, 32'h09);
  endtask
  task automatic t_battery();
    logic [31:0] v;
    for (int t = 0; t < 4; t++) begin
      v = {26'h0, t[1:0], 4'h1};
      wr(`HPEC_OFS_BATTERY, v);
      rd(`HPEC_OFS_BATTERY, v);
      chk({30'h0, BATTERY_THRESHOLD}, {30'h0, t[1:0]});
    end
    // Lowest trip level first: a battery below only the upper levels is not low there
    wr(`HPEC_OFS_BATTERY, 32'h01);
    wr(`HPEC_OFS_CLEAR, 32'h7F);
    BATTERY_BELOW <= 4'hC;
    repeat (6) @(posedge CLOCK);
    rd(`HPEC_OFS_RAW, 32'h01);
    wr(`HPEC_OFS_BATTERY, 32'h21);
    repeat (6) @(posedge CLOCK);
    rd(`HPEC_OFS_RAW, 32'h05);
  endtask
  // Wake is programmed before every request
  task automatic t_hibernate();
    wr(`HPEC_OFS_CTRL, 32'h3);
    rd(`HPEC_OFS_CTRL, 32'h3);
    chk({31'h0, GPIO_RETAIN}, 32'h1);
    wr(`HPEC_OFS_WAKECFG, 32'h1);
    wr(`HPEC_OFS_BATTERY, 32'h23);
    wr(`HPEC_OFS_REQUEST, 32'h1);
    repeat (10) @(posedge CLOCK);
    chk({31'h0, power_good}, 32'h1);
    BATTERY_BELOW <= 4'h0;
    repeat (6) @(posedge CLOCK);
    wr(`HPEC_OFS_REQUEST, 32'h1);
    wait_power(1'b0);
    pulse(4'h1);
    wait_power(1'b1);
    // Second sleep woken by the seconds match, third by a GPIO pin
    wr(`HPEC_OFS_WAKECFG, 32'h2);
    SECONDS <= 32'h4;
    wr(`HPEC_OFS_REQUEST, 32'h1);
    wait_power(1'b0);
    SECONDS <= 32'h5;
    wait_power(1'b1);
    wr(`HPEC_OFS_WAKECFG, 32'h4);
    wr(`HPEC_OFS_REQUEST, 32'h1);
    wait_power(1'b0);
    wr(`HPEC_OFS_CLEAR, 32'h7F);
    pulse(4'h4);
    wait_power(1'b1);
    rd(`HPEC_OFS_RAW, 32'h41);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge CLOCK);
    RSTN <= 1'b1;
    t_reset();
    t_masks();
    t_events();
    t_match();
    t_battery();
    t_hibernate();
    end_of_test();
  end
  // The whole run is a few hundred cycles; this span is far beyond it
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
